// [logic/ntbar_pkg.sv]
// ----------------------------------------------------------------
// register map, field layout and reset values of the window setup
// ----------------------------------------------------------------
package ntbar_pkg;
    // word offsets on the configuration bus (byte addresses)
    localparam logic [7:0] NTBAR_W1_REMAP_OFF = 8'h88; // upper half of 64-bit remap
    localparam logic [7:0] NTBAR_W2_CFG_OFF = 8'h8C; // window2_config
    localparam logic [7:0] NTBAR_W2_REMAP_OFF = 8'h90; // window2_remap_base
    localparam logic [7:0] NTBAR_W3_CFG_OFF = 8'h94; // window3_config
    localparam logic [7:0] NTBAR_W2_BAR_OFF = 8'h98; // window 2 base as the far side sees it
    localparam logic [7:0] NTBAR_W3_BAR_OFF = 8'h9C; // window 3 base as the far side sees it

    // setup register fields
    localparam int NTBAR_KIND_BIT = 0; // space_kind_select: 0 memory, 1 i/o
    localparam int NTBAR_WIDTH_LO = 1; // address width code, low bit
    localparam int NTBAR_WIDTH_HI = 2; // address width code, high bit
    localparam int NTBAR_CACHE_BIT = 3; // cacheable_window_select
    localparam int NTBAR_EN_BIT = 31; // window enable
    localparam int NTBAR_BASE_LO = 4; // lowest bit of window_base_field

    // address width codes
    localparam logic [1:0] NTBAR_WIDTH_32 = 2'h0;
    localparam logic [1:0] NTBAR_WIDTH_64 = 2'h2;

    // writable bits of each register; all others are stored as zero
    localparam logic [31:0] NTBAR_W1_REMAP_WMASK = 32'hFFFFFFFF;
    localparam logic [31:0] NTBAR_W2_CFG_WMASK = 32'h800003FF;
    localparam logic [31:0] NTBAR_W3_CFG_WMASK = 32'h800003F9;
    localparam logic [31:0] NTBAR_REMAP_WMASK = 32'hFFFFFFF0;
    localparam logic [31:0] NTBAR_BASE_WMASK = 32'hFFFFFFF0;
    localparam logic [31:0] NTBAR_FULL_WMASK = 32'hFFFFFFFF;

    // power-on value of every setup register
    localparam logic [31:0] NTBAR_REG_RESET = 32'h00000000;
endpackage

// [logic/ntbar_bar_image.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// read image of one window base as seen from the far side
// ----------------------------------------------------------------
module ntbar_bar_image
    import ntbar_pkg::*;
(
    input wire logic enable_i,
    input wire logic upper_half_i,
    input wire logic [3:0] attr_i,
    input wire logic [31:0] base_i,
    output logic [31:0] image_o
);
    // a disabled window reads as all zero
    // the upper half of a paired window is plain address bits, no attributes
    wire [31:0] low_image = {base_i[31:NTBAR_BASE_LO], attr_i};
    wire [31:0] live_image = upper_half_i ? base_i : low_image;

    assign image_o = enable_i ? live_image : 32'h00000000;
endmodule

// [logic/ntbar_regs.sv]
`timescale 1ns/100ps
// How it works
// - enable bit clear makes window read zero
// - setup survives link and hot resets
// - window 2 remap field gives translated base
// - 64-bit remap joins window 1 upper half
// - memory plus 64-bit pairs window 3 upper
// - paired window 3 setup reads zero, ignores writes
// - window 3 space kind shown in image
// - i/o space forces address width zero
// - window 3 supports only 32-bit width code
// - window 3 cacheable bit shown in image
// - width code 2 means 64-bit addressing
module ntbar_regs
    import ntbar_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cold_rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic [63:0] remapped_window_base_o,
    output logic window2_enable_o,
    output logic window3_enable_o,
    output logic window2_wide_o
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [31:0] w1_remap_reg; // window1_remap_base
    logic [31:0] w2_cfg_reg; // window2_config
    logic [31:0] w2_remap_reg; // window2_remap_base
    logic [31:0] w3_cfg_reg; // window3_config as stored
    logic [31:0] w2_base_reg; // window 2 base field
    logic [31:0] w3_base_reg; // window 3 base, or upper half of window 2
    logic ack_reg; // bus acknowledge
    logic [31:0] dat_reg; // bus read data
    logic [63:0] remap_reg; // translated base towards the datapath
    logic w2_en_reg; // window 2 live
    logic w3_en_reg; // window 3 live
    logic wide_reg; // window 2 uses 64-bit addressing

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // a request is seen on the first cycle, the write lands on the ack edge
    wire req = cyc_i & stb_i;
    wire rd_take = req & ~we_i & ~ack_reg;
    wire wr_fire = req & we_i & ack_reg;
    wire [7:0] word_adr = {adr_i[7:2], 2'b00};
    wire hit_w1r = word_adr == NTBAR_W1_REMAP_OFF;
    wire hit_w2c = word_adr == NTBAR_W2_CFG_OFF;
    wire hit_w2r = word_adr == NTBAR_W2_REMAP_OFF;
    wire hit_w3c = word_adr == NTBAR_W3_CFG_OFF;
    wire hit_w2b = word_adr == NTBAR_W2_BAR_OFF;
    wire hit_w3b = word_adr == NTBAR_W3_BAR_OFF;
    // byte lanes the master wants to change
    wire [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    // ----------------------------------------------------------------
    // window pairing
    // ----------------------------------------------------------------
    wire [1:0] w2_width = w2_cfg_reg[NTBAR_WIDTH_HI:NTBAR_WIDTH_LO];
    // memory space plus width code 2 turns window 3 into an upper half
    wire paired = ~w2_cfg_reg[NTBAR_KIND_BIT] & (w2_width == NTBAR_WIDTH_64);
    wire w2_en = w2_cfg_reg[NTBAR_EN_BIT];
    wire w3_en = w3_cfg_reg[NTBAR_EN_BIT];
    // paired window 3 setup is hidden behind a constant zero
    wire [31:0] w3_cfg_view = paired ? 32'h00000000 : w3_cfg_reg;

    // ----------------------------------------------------------------
    // next values of the setup registers
    // ----------------------------------------------------------------
    // byte merge keeps lanes the master did not select
    wire [31:0] w1_merge = (w1_remap_reg & ~lane_mask) | (dat_i & lane_mask);
    wire [31:0] w2c_merge = (w2_cfg_reg & ~lane_mask) | (dat_i & lane_mask);
    wire [31:0] w2r_merge = (w2_remap_reg & ~lane_mask) | (dat_i & lane_mask);
    wire [31:0] w3c_merge = (w3_cfg_reg & ~lane_mask) | (dat_i & lane_mask);
    wire [31:0] w2b_merge = (w2_base_reg & ~lane_mask) | (dat_i & lane_mask);
    wire [31:0] w3b_merge = (w3_base_reg & ~lane_mask) | (dat_i & lane_mask);

    wire [31:0] w1_next = w1_merge & NTBAR_W1_REMAP_WMASK;
    wire [31:0] w2r_next = w2r_merge & NTBAR_REMAP_WMASK;
    wire [31:0] w2c_keep = w2c_merge & NTBAR_W2_CFG_WMASK;
    // i/o space has no width choice, the width code drops to zero
    wire [31:0] w2c_next = w2c_keep[NTBAR_KIND_BIT] ? (w2c_keep & 32'hFFFFFFF9) : w2c_keep;
    // window 3 width bits are never stored, so codes 1 to 3 cannot stick
    wire [31:0] w3c_next = w3c_merge & NTBAR_W3_CFG_WMASK;
    wire [31:0] w2b_next = w2b_merge & NTBAR_BASE_WMASK;
    // as an upper half every bit of window 3 is address
    wire [31:0] w3b_mask = paired ? NTBAR_FULL_WMASK : NTBAR_BASE_WMASK;
    wire [31:0] w3b_next = w3b_merge & w3b_mask;

    // ----------------------------------------------------------------
    // window images seen by the far side
    // ----------------------------------------------------------------
    wire [31:0] w2_image;
    wire [31:0] w3_image;
    wire w3_live = paired ? w2_en : w3_en;

    // window 2 image, zero while disabled
    ntbar_bar_image u_w2_image (
        .enable_i(w2_en),
        .upper_half_i(1'b0),
        .attr_i(w2_cfg_reg[3:0]),
        .base_i(w2_base_reg),
        .image_o(w2_image)
    );

    // window 3 image: own attributes, or upper address of window 2
    ntbar_bar_image u_w3_image (
        .enable_i(w3_live),
        .upper_half_i(paired),
        .attr_i(w3_cfg_view[3:0]),
        .base_i(w3_base_reg),
        .image_o(w3_image)
    );

    // ----------------------------------------------------------------
    // read selection
    // ----------------------------------------------------------------
    // unmapped words are acknowledged and read as zero
    wire [31:0] rd_mux =
        hit_w1r ? w1_remap_reg :
        hit_w2c ? w2_cfg_reg :
        hit_w2r ? w2_remap_reg :
        hit_w3c ? w3_cfg_view :
        hit_w2b ? w2_image :
        hit_w3b ? w3_image : 32'h00000000;

    // translated base: upper word only in 64-bit mode
    wire [31:0] remap_hi = paired ? w1_remap_reg : 32'h00000000;
    wire [63:0] remap_calc = {remap_hi, w2_remap_reg};

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    // ack rises one cycle after the request and drops the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i || cold_rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= req & ~ack_reg;
            // read data is latched with the ack and held while it stands
            if (rd_take) begin
                dat_reg <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // setup registers
    // ----------------------------------------------------------------
    // only the cold start clears them, so a link or hot reset leaves the
    // windows intact; the price is that software owns all cleanup
    always_ff @(posedge clk_i) begin
        if (cold_rst_i) begin
            w1_remap_reg <= NTBAR_REG_RESET;
            w2_cfg_reg <= NTBAR_REG_RESET;
            w2_remap_reg <= NTBAR_REG_RESET;
            w3_cfg_reg <= NTBAR_REG_RESET;
        end else if (wr_fire) begin
            if (hit_w1r) begin
                w1_remap_reg <= w1_next;
            end
            if (hit_w2c) begin
                w2_cfg_reg <= w2c_next;
            end
            if (hit_w2r) begin
                w2_remap_reg <= w2r_next;
            end
            // writes bounce off while window 3 is an upper half
            if (hit_w3c && !paired) begin
                w3_cfg_reg <= w3c_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // window base fields
    // ----------------------------------------------------------------
    // a disabled window holds a read-only zero image, so writes are dropped
    always_ff @(posedge clk_i) begin
        if (cold_rst_i) begin
            w2_base_reg <= NTBAR_REG_RESET;
            w3_base_reg <= NTBAR_REG_RESET;
        end else if (wr_fire) begin
            if (hit_w2b && w2_en) begin
                w2_base_reg <= w2b_next;
            end
            if (hit_w3b && w3_live) begin
                w3_base_reg <= w3b_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs towards the address datapath
    // ----------------------------------------------------------------
    // registered, so the datapath sees each setup change one edge later
    always_ff @(posedge clk_i) begin
        if (rst_i || cold_rst_i) begin
            remap_reg <= 64'h0000000000000000;
            w2_en_reg <= 1'b0;
            w3_en_reg <= 1'b0;
            wide_reg <= 1'b0;
        end else begin
            remap_reg <= remap_calc;
            w2_en_reg <= w2_en;
            w3_en_reg <= w3_en & ~paired;
            wide_reg <= paired;
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign remapped_window_base_o = remap_reg;
    assign window2_enable_o = w2_en_reg;
    assign window3_enable_o = w3_en_reg;
    assign window2_wide_o = wide_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || cold_rst_i);

    // ack is a single-cycle answer one cycle after the request
    a_ack_single_cycle: assert property (
        (req && !ack_reg && !ack_o) |=> ack_o ##1 !ack_o
    ) else $error("ack did not pulse for one cycle");

    // a disabled window 2 reads back zero
    a_bar2_off_zero: assert property (
        (rd_take && hit_w2b && !w2_en) |=> (dat_o == 32'h00000000)
    ) else $error("disabled window 2 read nonzero");

    // hot reset leaves the remap base as it was
    a_remap_hot_keep: assert property (
        @(posedge clk_i) disable iff (cold_rst_i)
        (rst_i && $past(rst_i)) |-> $stable(w2_remap_reg)
    ) else $error("remap base changed across hot reset");

    // a full-word write reaches the datapath two edges later, low nibble zero
    a_remap_write_path: assert property (
        (wr_fire && hit_w2r && sel_i == 4'hF) |-> ##2
        (remapped_window_base_o[31:4] == $past(dat_i[31:4], 2)) &&
        (remapped_window_base_o[3:0] == 4'h0)
    ) else $error("remap base not forwarded");

    // the upper translated word is window 1 only in 64-bit mode
    // the first cycle must be out of reset, else the output flop was still cleared
    a_upper_half_join: assert property (
        ((paired && !rst_i && !cold_rst_i) ##1 paired) |->
        (remapped_window_base_o[63:32] == $past(w1_remap_reg))
    ) else $error("upper translated word wrong in 64-bit mode");

    a_upper_half_zero: assert property (
        (!paired ##1 !paired) |-> (remapped_window_base_o[63:32] == 32'h00000000)
    ) else $error("upper translated word nonzero in 32-bit mode");

    // paired window 3 image returns the full upper address
    a_bar3_upper_read: assert property (
        (rd_take && hit_w3b && paired && w2_en) |=> (dat_o == $past(w3_base_reg))
    ) else $error("paired window 3 image wrong");

    // paired window 3 setup reads zero and keeps its store
    a_w3_paired_zero: assert property (
        (rd_take && hit_w3c && paired) |=> (dat_o == 32'h00000000)
    ) else $error("paired window 3 setup read nonzero");

    a_w3_write_ignored: assert property (
        (wr_fire && hit_w3c && paired) |=> $stable(w3_cfg_reg)
    ) else $error("paired window 3 setup took a write");

    // window 3 image carries its space kind and cacheable bits
    a_w3_kind_shown: assert property (
        (rd_take && hit_w3b && !paired && w3_en) |=>
        (dat_o[NTBAR_KIND_BIT] == $past(w3_cfg_reg[NTBAR_KIND_BIT]))
    ) else $error("window 3 space kind not shown");

    a_w3_cache_shown: assert property (
        (rd_take && hit_w3b && !paired && w3_en) |=>
        (dat_o[NTBAR_CACHE_BIT] == $past(w3_cfg_reg[NTBAR_CACHE_BIT]))
    ) else $error("window 3 cacheable bit not shown");

    // i/o space never carries a width code
    a_io_width_zero: assert property (
        (wr_fire && hit_w2c && dat_i[NTBAR_KIND_BIT] && sel_i[0]) |=>
        (w2_cfg_reg[NTBAR_WIDTH_HI:NTBAR_WIDTH_LO] == 2'h0)
    ) else $error("i/o window kept a width code");

    // window 3 width code only ever holds 32-bit
    a_w3_width_fixed: assert property (
        w3_cfg_reg[NTBAR_WIDTH_HI:NTBAR_WIDTH_LO] == NTBAR_WIDTH_32
    ) else $error("window 3 holds a reserved width code");

    // width code 2 on a memory window raises the wide flag next cycle
    // a reset edge clears the flag although the setup survives, so skip it
    a_wide_on_code2: assert property (
        (!rst_i && !cold_rst_i && !w2_cfg_reg[NTBAR_KIND_BIT] &&
        w2_width == NTBAR_WIDTH_64) |=> window2_wide_o
    ) else $error("width code 2 not treated as 64-bit");

    // reserved bits of window 2 setup stay zero
    a_reserved_zero: assert property (
        (w2_cfg_reg & ~NTBAR_W2_CFG_WMASK) == 32'h00000000
    ) else $error("reserved setup bits set");
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
    import ntbar_pkg::*;
    // ----------------------------------------------------------------
    // stimulus, design outputs and the reference copy of the registers
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1; // hot reset
    logic cold_rst_i = 1'b1; // cold start reset
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    logic [63:0] remap_o;
    logic w2_en_o;
    logic w3_en_o;
    logic w2_wide_o;
    logic [31:0] m_rem1, m_cfg2, m_rem2, m_cfg3, m_b2, m_b3; // reference registers
    logic [31:0] rd; // last read data
    logic [31:0] lfsr = 32'h7509D3ED;
    logic [7:0] adr_tab [8] = '{8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0, 8'h00};
    int error_cnt = 0;
    int total_checks = 0;

    always #50 clk_i = ~clk_i; // 10 MHz

    ntbar_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .cold_rst_i(cold_rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .remapped_window_base_o(remap_o),
        .window2_enable_o(w2_en_o), .window3_enable_o(w3_en_o), .window2_wide_o(w2_wide_o));

    // ----------------------------------------------------------------
    // reference functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    // memory space with width code 2 hands window 3 over as upper half
    function automatic logic paired();
        return !m_cfg2[NTBAR_KIND_BIT] && m_cfg2[2:1] == 2'h2;
    endfunction

    // byte lanes not selected keep the old value
    function automatic logic [31:0] merge(input logic [31:0] old, d, input logic [3:0] s,
        input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return ((old & ~m) | (d & m)) & mask;
    endfunction

    function automatic logic [31:0] expect_rd(input logic [7:0] a);
        case (a)
            8'h88: return m_rem1;
            8'h8C: return m_cfg2;
            8'h90: return m_rem2;
            8'h94: return paired() ? 32'h00000000 : m_cfg3;
            8'h98: return m_cfg2[31] ? {m_b2[31:4], m_cfg2[3:0]} : 32'h00000000;
            // paired: the whole word is upper address, gated by window 2 enable
            8'h9C: return paired() ? (m_cfg2[31] ? m_b3 : 32'h00000000) :
                (m_cfg3[31] ? {m_b3[31:4], m_cfg3[3:0]} : 32'h00000000);
            default: return 32'h00000000; // unmapped reads as zero
        endcase
    endfunction

    task automatic model_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        case (a)
            8'h88: m_rem1 = merge(m_rem1, d, s, NTBAR_W1_REMAP_WMASK);
            8'h8C: begin
                m_cfg2 = merge(m_cfg2, d, s, NTBAR_W2_CFG_WMASK);
                if (m_cfg2[0]) m_cfg2[2:1] = 2'h0;
            end
            8'h90: m_rem2 = merge(m_rem2, d, s, NTBAR_REMAP_WMASK);
            8'h94: if (!paired()) m_cfg3 = merge(m_cfg3, d, s, NTBAR_W3_CFG_WMASK);
            8'h98: if (m_cfg2[31]) m_b2 = merge(m_b2, d, s, NTBAR_BASE_WMASK);
            8'h9C: begin
                if (paired() && m_cfg2[31]) m_b3 = merge(m_b3, d, s, NTBAR_FULL_WMASK);
                else if (!paired() && m_cfg3[31]) m_b3 = merge(m_b3, d, s, NTBAR_BASE_WMASK);
            end
            default: ;
        endcase
    endtask

    task automatic model_clear();
        {m_rem1, m_cfg2, m_rem2, m_cfg3, m_b2, m_b3} = {6{NTBAR_REG_RESET}};
    endtask

    // ----------------------------------------------------------------
    // checking, bus cycles and the closing report
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // classic cycle; the idle edge in front keeps cyc low one cycle between cycles
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        if (n == 20) begin
            error_cnt++;
            report_and_stop();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (w) model_write(a, d, s);
    endtask

    task automatic rd_chk(input logic [7:0] a);
        bus(1'b0, a, 4'hF, 32'h00000000);
        chk({32'h0, rd}, {32'h0, expect_rd(a)});
    endtask

    // datapath outputs follow one edge after the store; sample a settled value
    task automatic out_chk();
        repeat (2) @(posedge clk_i);
        chk(w2_en_o, m_cfg2[31]);
        chk(w2_wide_o, paired());
        chk(w3_en_o, m_cfg3[31] & !paired());
        chk(remap_o, {paired() ? m_rem1 : 32'h0, m_rem2[31:4], 4'h0});
        chk(remap_o[31:0], {m_rem2[31:4], 4'h0});
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        model_clear();
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        cold_rst_i <= 1'b0;
        // every register starts at zero, unmapped places read zero
        foreach (adr_tab[i]) rd_chk(adr_tab[i]);
        out_chk();
        $display("test reset values done");
        // corner: window 3 setup before, during and after pairing
        bus(1'b1, 8'h94, 4'hF, 32'hFFFFFFFF);
        chk(m_cfg3, 32'h800003F9);
        rd_chk(8'h94);
        bus(1'b1, 8'h88, 4'hF, 32'hA5A5C3C3);
        bus(1'b1, 8'h8C, 4'hF, 32'h80000004);
        out_chk();
        rd_chk(8'h94);
        // paired window 3 takes all 32 bits as upper address
        bus(1'b1, 8'h9C, 4'hF, 32'h12345678);
        rd_chk(8'h9C);
        bus(1'b1, 8'h94, 4'hF, 32'h00000008);
        bus(1'b1, 8'h8C, 4'hF, 32'h80000005);
        rd_chk(8'h8C);
        rd_chk(8'h94);
        rd_chk(8'h9C);
        out_chk();
        $display("test pairing done");
        // random traffic across all offsets and byte lanes
        for (int i = 0; i < 400; i++) begin
            logic [7:0] a;
            logic [3:0] s;
            lfsr = lfsr_next(lfsr);
            a = adr_tab[lfsr[2:0]];
            s = lfsr[5] ? 4'hF : lfsr[9:6];
            if (lfsr[3]) bus(1'b1, a, s, lfsr_next(lfsr));
            else rd_chk(a);
            if (lfsr[4]) out_chk();
        end
        $display("test random traffic done");
        // hot reset keeps every setup value
        @(posedge clk_i);
        rst_i <= 1'b1;
        // held several edges so the hot reset retention assertion is exercised
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(ack_o, 1'b0);
        out_chk();
        foreach (adr_tab[i]) rd_chk(adr_tab[i]);
        // cold reset clears them
        @(posedge clk_i);
        cold_rst_i <= 1'b1;
        @(posedge clk_i);
        cold_rst_i <= 1'b0;
        model_clear();
        foreach (adr_tab[i]) rd_chk(adr_tab[i]);
        out_chk();
        $display("test resets done");
        report_and_stop();
    end
endmodule
